// ---- rtl/cli_pkg.sv ----
// cold-load / inrush detector: shared constants, register map and types.
// assumes a 10 MHz core clock and per-unit magnitudes from the front end.
package cli_pkg;

  // timing
  localparam int unsigned CLK_HZ          = 10_000_000;
  localparam int unsigned WINDOW_MS       = 80;
  localparam int unsigned WIN_CYCLES      = WINDOW_MS * (CLK_HZ / 1000);
  localparam int unsigned STEP_MS         = 10;
  localparam int unsigned STEP_CYCLES     = STEP_MS * (CLK_HZ / 1000);
  localparam int unsigned FIRST_CYC_STB   = 2;

  // setting ranges, units 0.01 x In, 0.01 s and percent
  localparam logic [15:0] IDLE_MIN  = 16'h0001;
  localparam logic [15:0] IDLE_MAX  = 16'h0032;
  localparam logic [15:0] START_MIN = 16'h001E;
  localparam logic [15:0] START_MAX = 16'h03E8;
  localparam logic [15:0] MAXT_MIN  = 16'h0001;
  localparam logic [15:0] MAXT_MAX  = 16'h7530;
  localparam logic [15:0] H2_MIN    = 16'h0000;
  localparam logic [15:0] H2_MAX    = 16'h0063;

  // reset values
  localparam logic [15:0] IDLE_RST  = 16'h000A;
  localparam logic [15:0] START_RST = 16'h0078;
  localparam logic [15:0] MAXT_RST  = 16'h0064;
  localparam logic [6:0]  H2_RST    = 7'h0F;

  // register byte addresses
  localparam logic [7:0] A_CTRL     = 8'h00;
  localparam logic [7:0] A_IDLE     = 8'h04;
  localparam logic [7:0] A_START    = 8'h08;
  localparam logic [7:0] A_MAXT     = 8'h0C;
  localparam logic [7:0] A_H2       = 8'h10;
  localparam logic [7:0] A_STATUS   = 8'h14;
  localparam logic [7:0] A_IRQ_STAT = 8'h18;
  localparam logic [7:0] A_IRQ_MASK = 8'h1C;

  // event bit positions in status and mask
  localparam int unsigned EV_COLD_ON  = 0;
  localparam int unsigned EV_INR_ON   = 1;
  localparam int unsigned EV_COLD_OFF = 2;
  localparam int unsigned EV_W        = 3;

  typedef enum logic [3:0] {
    ST_NOT_IDLE = 4'h1,
    ST_IDLE     = 4'h2,
    ST_RISE     = 4'h4,
    ST_ACTIVE   = 4'h8
  } cli_det_e;

  // one measurement update from the front end
  typedef struct packed {
    logic [2:0][15:0] mag;   // fundamental, 0.01 x In per lsb
    logic [2:0][7:0]  ratio; // second_harmonic_ratio, percent
  } cli_meas_s;

endpackage

// ---- rtl/cli_detector.sv ----
// cold-load pickup and magnetizing inrush detector with an APB register file.
// assumes measurement strobe and data come from logic on core_clk.
// What this block does
// - cold load is declared when all phases were idle and one passes start within 80 ms.
// - cold load stays until the maximum time runs out or current drops below start.
// - cold-load and inrush outputs are plain signals for output and blocking matrices.
// - inrush needs the cold-load condition plus a phase ratio above the harmonic setting.
// - a harmonic setting of zero makes inrush follow cold load exactly.
// - inrush blocking starts on the cold-load start condition at once.
// - after the first full cycle inrush stays while a phase ratio is high.
// - after the first cycle inrush drops when no phase ratio is high.
// - no activation unless currents first dropped below idle.
// - no activation when current lingers between idle and start over 80 ms.
// - the idle threshold spans 0.01 to 0.50 x In.
// - the start threshold spans 0.30 to 10.00 x In.
// - maximum time spans up to 300.00 s in 0.01 s steps, the least being instantaneous.
// - the harmonic setting spans 0 to 99 percent.
//
// Local design decisions: the APB slave port and the register offsets.
`timescale 1ns/1ns

module cli_detector #(
  parameter int unsigned WINDOW_CYCLES = cli_pkg::WIN_CYCLES,
  parameter int unsigned STEP_CYC      = cli_pkg::STEP_CYCLES
) (
  input  wire logic              core_clk,   // system clock
  input  wire logic              reset_n,    // sync reset, active low
  input  wire logic              psel,       // apb select
  input  wire logic              penable,    // apb access phase
  input  wire logic              pwrite,     // apb direction
  input  wire logic [7:0]        paddr,      // apb byte address
  input  wire logic [31:0]       pwdata,     // apb write data
  output logic      [31:0]       prdata,     // apb read data
  output logic                   pready,     // apb ready
  output logic                   pslverr,    // apb error on unmapped address
  input  wire logic              meas_stb,   // new measurement, one cycle
  input  wire cli_pkg::cli_meas_s meas,      // per-phase data
  output logic                   cold_load,  // cold-load detection level
  output logic                   inrush,     // inrush detection level
  output logic                   irq         // level interrupt
);

  typedef struct packed {
    cli_pkg::cli_det_e            st;
    logic [19:0]                  win_cnt;
    logic [19:0]                  step_cnt;
    logic [15:0]                  act_cnt;
    logic [1:0]                   cyc_cnt;
    logic                         h2_hold;
    logic                         cold;
    logic                         inr;
    logic                         en;
    logic [15:0]                  idle_thr;
    logic [15:0]                  start_thr;
    logic [15:0]                  max_t;
    logic [6:0]                   h2_set;
    logic [cli_pkg::EV_W-1:0]     irq_stat;
    logic [cli_pkg::EV_W-1:0]     irq_mask;
    logic                         irq;
    logic                         pready;
    logic                         pslverr;
    logic [31:0]                  prdata;
  } cli_state_s;

  localparam cli_state_s RST = '{
    st:        cli_pkg::ST_NOT_IDLE,
    win_cnt:   20'h00000,
    step_cnt:  20'h00000,
    act_cnt:   16'h0000,
    cyc_cnt:   2'h0,
    h2_hold:   1'b0,
    cold:      1'b0,
    inr:       1'b0,
    en:        1'b1,
    idle_thr:  cli_pkg::IDLE_RST,
    start_thr: cli_pkg::START_RST,
    max_t:     cli_pkg::MAXT_RST,
    h2_set:    cli_pkg::H2_RST,
    irq_stat:  3'h0,
    irq_mask:  3'h0,
    irq:       1'b0,
    pready:    1'b0,
    pslverr:   1'b0,
    prdata:    32'h00000000
  };

  localparam logic [19:0] WIN_LAST  = 20'(WINDOW_CYCLES - 1);
  localparam logic [19:0] STEP_LAST = 20'(STEP_CYC - 1);
  localparam logic [1:0]  FIRST_CYC = 2'(cli_pkg::FIRST_CYC_STB);

  cli_state_s s_q;
  cli_state_s s_d;

  function automatic logic any_above(input logic [2:0][15:0] v, input logic [15:0] thr);
    logic r;
    r = 1'b0;
    for (int i = 0; i < 3; i++) begin
      r = r | (v[i] > thr);
    end
    return r;
  endfunction

  function automatic logic all_below(input logic [2:0][15:0] v, input logic [15:0] thr);
    logic r;
    r = 1'b1;
    for (int i = 0; i < 3; i++) begin
      r = r & (v[i] < thr);
    end
    return r;
  endfunction

  // out-of-range writes saturate, so the logic never sees an illegal setting
  function automatic logic [15:0] clamp(input logic [31:0] v, input logic [15:0] lo,
                                        input logic [15:0] hi);
    logic [15:0] r;
    r = v[15:0];
    if (v < {16'h0000, lo}) begin
      r = lo;
    end else if (v > {16'h0000, hi}) begin
      r = hi;
    end
    return r;
  endfunction

  function automatic logic ratio_high(input logic [2:0][7:0] rt, input logic [6:0] set);
    logic r;
    r = 1'b0;
    for (int i = 0; i < 3; i++) begin
      r = r | (rt[i] > {1'b0, set});
    end
    return r;
  endfunction

  logic                     idle_now;
  logic                     start_now;
  logic                     h2_now;
  logic                     wr_acc;
  logic                     step_tick;
  logic [cli_pkg::EV_W-1:0] ev;
  logic [cli_pkg::EV_W-1:0] w1c;
  logic [15:0]              clamped;

  always_comb begin
    s_d       = s_q;
    idle_now  = all_below(meas.mag, s_q.idle_thr);
    start_now = any_above(meas.mag, s_q.start_thr);
    h2_now    = ratio_high(meas.ratio, s_q.h2_set);
    ev        = '0;
    w1c       = '0;
    clamped   = 16'h0000;
    step_tick = (s_q.step_cnt == STEP_LAST);
    wr_acc    = psel & penable & s_q.pready & pwrite;

    // apb: decode in setup, answer registered in the first access cycle
    s_d.pready  = psel & ~penable;
    s_d.pslverr = 1'b0;
    s_d.prdata  = 32'h00000000;
    if (psel & ~penable) begin
      unique case (paddr)
        cli_pkg::A_CTRL:     s_d.prdata = {31'h00000000, s_q.en};
        cli_pkg::A_IDLE:     s_d.prdata = {16'h0000, s_q.idle_thr};
        cli_pkg::A_START:    s_d.prdata = {16'h0000, s_q.start_thr};
        cli_pkg::A_MAXT:     s_d.prdata = {16'h0000, s_q.max_t};
        cli_pkg::A_H2:       s_d.prdata = {25'h0000000, s_q.h2_set};
        cli_pkg::A_STATUS:   s_d.prdata = {26'h0000000, s_q.st, s_q.inr, s_q.cold};
        cli_pkg::A_IRQ_STAT: s_d.prdata = {29'h00000000, s_q.irq_stat};
        cli_pkg::A_IRQ_MASK: s_d.prdata = {29'h00000000, s_q.irq_mask};
        default:             s_d.pslverr = 1'b1;
      endcase
    end
    if (wr_acc) begin
      unique case (paddr)
        cli_pkg::A_CTRL: begin
          s_d.en = pwdata[0];
        end
        cli_pkg::A_IDLE: begin
          s_d.idle_thr = clamp(pwdata, cli_pkg::IDLE_MIN, cli_pkg::IDLE_MAX);
        end
        cli_pkg::A_START: begin
          s_d.start_thr = clamp(pwdata, cli_pkg::START_MIN, cli_pkg::START_MAX);
        end
        cli_pkg::A_MAXT: begin
          s_d.max_t = clamp(pwdata, cli_pkg::MAXT_MIN, cli_pkg::MAXT_MAX);
        end
        cli_pkg::A_H2: begin
          clamped    = clamp(pwdata, cli_pkg::H2_MIN, cli_pkg::H2_MAX);
          s_d.h2_set = clamped[6:0];
        end
        cli_pkg::A_IRQ_STAT: begin
          w1c = pwdata[cli_pkg::EV_W-1:0];
        end
        cli_pkg::A_IRQ_MASK: begin
          s_d.irq_mask = pwdata[cli_pkg::EV_W-1:0];
        end
        default: begin
        end
      endcase
    end

    // detector
    unique case (s_q.st)
      cli_pkg::ST_NOT_IDLE: begin
        if (meas_stb && idle_now) begin
          s_d.st = cli_pkg::ST_IDLE;
        end
      end
      cli_pkg::ST_IDLE: begin
        if (meas_stb && start_now) begin
          s_d.st = cli_pkg::ST_ACTIVE;
        end else if (meas_stb && !idle_now) begin
          s_d.st      = cli_pkg::ST_RISE;
          s_d.win_cnt = 20'h00000;
        end
      end
      cli_pkg::ST_RISE: begin
        s_d.win_cnt = s_q.win_cnt + 20'h00001;
        if (meas_stb && start_now) begin
          s_d.st = cli_pkg::ST_ACTIVE;
        end else if (meas_stb && idle_now) begin
          s_d.st = cli_pkg::ST_IDLE;
        end else if (s_q.win_cnt >= WIN_LAST) begin
          s_d.st = cli_pkg::ST_NOT_IDLE;
        end
      end
      cli_pkg::ST_ACTIVE: begin
        s_d.step_cnt = step_tick ? 20'h00000 : s_q.step_cnt + 20'h00001;
        if (step_tick) begin
          s_d.act_cnt = s_q.act_cnt + 16'h0001;
        end
        if (meas_stb) begin
          if (s_q.cyc_cnt < FIRST_CYC) begin
            s_d.cyc_cnt = s_q.cyc_cnt + 2'h1;
          end else begin
            s_d.h2_hold = h2_now;
          end
        end
        // a setting of one step ends at the first tick: the instantaneous case
        if ((step_tick && (s_d.act_cnt >= s_q.max_t)) ||
            (meas_stb && !start_now)) begin
          s_d.st = cli_pkg::ST_NOT_IDLE;
        end
      end
      default: begin
        s_d.st = cli_pkg::ST_NOT_IDLE;
      end
    endcase

    if (!s_q.en) begin
      s_d.st = cli_pkg::ST_NOT_IDLE;
    end
    if (s_d.st == cli_pkg::ST_ACTIVE && s_q.st != cli_pkg::ST_ACTIVE) begin
      s_d.step_cnt = 20'h00000;
      s_d.act_cnt  = 16'h0000;
      s_d.cyc_cnt  = 2'h0;
      s_d.h2_hold  = 1'b1;
    end

    // outputs follow the next state so they rise with the detection edge
    s_d.cold = (s_d.st == cli_pkg::ST_ACTIVE);
    s_d.inr  = s_d.cold & ((s_q.h2_set == 7'h00) | s_d.h2_hold);

    ev[cli_pkg::EV_COLD_ON]  = s_d.cold & ~s_q.cold;
    ev[cli_pkg::EV_INR_ON]   = s_d.inr & ~s_q.inr;
    ev[cli_pkg::EV_COLD_OFF] = ~s_d.cold & s_q.cold;
    // a new event wins over a clear in the same cycle
    s_d.irq_stat = (s_q.irq_stat & ~w1c) | ev;
    s_d.irq      = |(s_d.irq_stat & s_d.irq_mask);

    if (!reset_n) begin
      s_d = RST;
    end
  end

  always_ff @(posedge core_clk) begin
    s_q <= s_d;
  end

  assign prdata    = s_q.prdata;
  assign pready    = s_q.pready;
  assign pslverr   = s_q.pslverr;
  assign cold_load = s_q.cold;
  assign inrush    = s_q.inr;
  assign irq       = s_q.irq;

endmodule

// ---- dv/cli_detector_props.sv ----
// port checker for the cold-load / inrush detector.
// assumes it is bound onto cli_detector and sees only its ports.
`timescale 1ns/1ns
module cli_detector_chk (
  input wire logic        core_clk,  // clock
  input wire logic        reset_n,   // sync reset
  input wire logic        psel,      // apb select
  input wire logic        penable,   // apb access
  input wire logic        pwrite,    // apb write
  input wire logic [7:0]  paddr,     // apb address
  input wire logic [31:0] pwdata,    // apb wdata
  input wire logic        pready,    // apb ready
  input wire logic        pslverr,   // apb error
  input wire logic        meas_stb,  // strobe
  input wire logic        cold_load, // detect
  input wire logic        inrush     // detect
);
  logic [1:0] stb_cnt_q;
  logic       h2_zero_q;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  // strobes while active, saturating once past the first cycle
  always_ff @(posedge core_clk) begin
    if (!reset_n || !cold_load)
      stb_cnt_q <= 2'h0;
    else if (meas_stb && stb_cnt_q != 2'h3)
      stb_cnt_q <= stb_cnt_q + 2'h1;
    if (!reset_n)
      h2_zero_q <= 1'b0;
    else if (psel && penable && pready && pwrite && paddr == cli_pkg::A_H2)
      h2_zero_q <= pwdata == 32'h00000000;
  end
  property p_rst_clear; $rose(reset_n) |-> !cold_load && !inrush; endproperty
  a_rst_clear: assert property (p_rst_clear) else $error("outputs set after reset");
  property p_cold_stb; $rose(cold_load) |-> $past(meas_stb); endproperty
  a_cold_stb: assert property (p_cold_stb) else $error("cold load rose unstrobed");
  property p_inr_stb; $rose(inrush) |-> $past(meas_stb); endproperty
  a_inr_stb: assert property (p_inr_stb) else $error("inrush rose unstrobed");
  property p_inr_drop; $fell(inrush) && cold_load |-> $past(meas_stb); endproperty
  a_inr_drop: assert property (p_inr_drop) else $error("inrush fell unstrobed");
  property p_inr_sub; inrush |-> cold_load; endproperty
  a_inr_sub: assert property (p_inr_sub) else $error("inrush without cold load");
  property p_first_cyc; cold_load && stb_cnt_q != 2'h3 |-> inrush; endproperty
  a_first_cyc: assert property (p_first_cyc) else $error("inrush lost in first cycle");
  // the new setting reaches the outputs one edge after it is written
  property p_h2_zero; h2_zero_q && $past(h2_zero_q) |-> inrush == cold_load; endproperty
  a_h2_zero: assert property (p_h2_zero) else $error("inrush differs at zero h2");
  property p_apb_rdy; psel && !penable |=> pready ##1 !pready; endproperty
  a_apb_rdy: assert property (p_apb_rdy) else $error("apb ready not one cycle");
  property p_apb_err; pslverr |-> pready && psel && penable; endproperty
  a_apb_err: assert property (p_apb_err) else $error("apb error outside access");
endmodule
bind cli_detector cli_detector_chk u_chk (.core_clk(core_clk), .reset_n(reset_n),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pready(pready), .pslverr(pslverr), .meas_stb(meas_stb), .cold_load(cold_load),
  .inrush(inrush));

// ---- dv/cli_matrix_model.sv ----
// far-end model: blocking matrix counting inrush block requests.
// assumes detector outputs are levels on core_clk.
`timescale 1ns/1ns
module cli_matrix_model (
  input  wire logic       core_clk,  // clock
  input  wire logic       reset_n,   // sync reset
  input  wire logic       cold_load, // group switch
  input  wire logic       inrush,    // stage block
  output logic      [7:0] blk_cnt_q  // blocks seen
);
  logic inr_q;
  always_ff @(posedge core_clk) begin
    inr_q <= inrush;
    if (!reset_n)
      blk_cnt_q <= 8'h00;
    else if (inrush && !inr_q && cold_load)
      blk_cnt_q <= blk_cnt_q + 8'h01;
  end
endmodule

// ---- dv/tb.sv ----
// self-checking bench: apb master, strobe driver, queue scoreboard.
// assumes cli_pkg, the far-end model and the bound checker compile first.
`timescale 1ns/1ns
module tb;
  localparam logic [15:0] HI  = 16'h00C8;
  localparam logic [15:0] MID = 16'h0064;
  localparam logic [15:0] LO  = 16'h0005;
  logic               core_clk, reset_n, psel, penable, pwrite, meas_stb;
  logic               pready, pslverr, cold_load, inrush, irq;
  logic               stb_d = 1'b0;
  logic [7:0]         paddr, blk_cnt;
  logic [31:0]        pwdata, prdata, rnd;
  logic [31:0]        exp_q[$];
  cli_pkg::cli_meas_s meas;
  int                 err_total, compares, seed;
  logic [23:0]        dflt_t[8] = '{24'h000001, 24'h04000A, 24'h080078, 24'h0C0064,
                                    24'h10000F, 24'h140004, 24'h180000, 24'h1C0000};
  // address, write value, clamped read-back
  logic [39:0]        clamp_t[11] = '{40'h0400000001, 40'h0401000032, 40'h04000A000A,
    40'h080005001E, 40'h08FFFF03E8, 40'h0800780078, 40'h0C00000001, 40'h0CFFFF7530,
    40'h0C00640064, 40'h1000FF0063, 40'h10000F000F};
  cli_detector #(.WINDOW_CYCLES(40), .STEP_CYC(8)) u_cli_detector (.core_clk(core_clk),
    .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .meas_stb(meas_stb), .meas(meas), .cold_load(cold_load), .inrush(inrush), .irq(irq));
  cli_matrix_model u_cli_matrix_model (.core_clk(core_clk), .reset_n(reset_n),
    .cold_load(cold_load), .inrush(inrush), .blk_cnt_q(blk_cnt));
  always #50 core_clk = ~core_clk;
  task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
    compares++;
    if (s !== e) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic conclude;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic apb(logic wr, logic [7:0] a, logic [31:0] d, logic [31:0] e);
    int n;
    n = 0;
    @(posedge core_clk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    if (!wr)
      exp_q.push_back(e);
    @(posedge core_clk);
    penable <= 1'b1;
    // ready is looked at mid-cycle where it has settled, the transfer ends at the next edge
    @(negedge core_clk);
    while (pready !== 1'b1 && n < 20) begin
      n++;
      @(negedge core_clk);
    end
    if (n == 20)
      err_total++;
    @(posedge core_clk);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  // phases a and c stay low, ratio rides on phase b
  task automatic stb(logic [15:0] m, logic [2:0] e, logic [7:0] r = 8'h00);
    @(posedge core_clk);
    meas_stb   <= 1'b1;
    meas.mag   <= {LO, m, LO};
    meas.ratio <= {8'h00, r, 8'h00};
    exp_q.push_back({29'h0, e});
    @(posedge core_clk);
    meas_stb <= 1'b0;
  endtask
  task automatic idle;
    rnd = $random(seed);
    stb({13'h0, rnd[2:0]}, 3'h0, rnd[15:8]);
  endtask
  always @(negedge core_clk) begin
    if (pready && !pwrite)
      chk("prdata", exp_q.pop_front(), {pslverr, prdata[30:0]});
    if (stb_d)
      chk("outputs", exp_q.pop_front(), {29'h0, irq, cold_load, inrush});
    stb_d = meas_stb;
  end
  initial begin
    #2_000_000;
    err_total++;
    conclude();
  end
  initial begin
    core_clk = 1'b0;
    reset_n  = 1'b0;
    {psel, penable, pwrite, meas_stb} = 4'h0;
    paddr  = 8'h00;
    pwdata = 32'h0;
    meas   = '0;
    seed   = 82;
    repeat (6) @(posedge core_clk);
    reset_n <= 1'b1;
    foreach (dflt_t[i]) apb(1'b0, dflt_t[i][23:16], 32'h0, {16'h0, dflt_t[i][15:0]});
    apb(1'b0, 8'h20, 32'h0, 32'h8000_0000);
    foreach (clamp_t[i]) begin
      apb(1'b1, clamp_t[i][39:32], {16'h0, clamp_t[i][31:16]}, 32'h0);
      apb(1'b0, clamp_t[i][39:32], 32'h0, {16'h0, clamp_t[i][15:0]});
    end
    apb(1'b1, 8'h1C, 32'h1, 32'h0);
    stb(HI, 3'h0);
    idle();
    stb(HI, 3'h7);
    repeat (2) stb(HI, 3'h7);
    stb(HI, 3'h6);
    stb(HI, 3'h7, {2'b01, rnd[21:16]});
    stb(MID, 3'h4);
    apb(1'b0, 8'h18, 32'h0, 32'h7);
    apb(1'b1, 8'h18, 32'h7, 32'h0);
    apb(1'b0, 8'h18, 32'h0, 32'h0);
    apb(1'b1, 8'h1C, 32'h0, 32'h0);
    idle();
    stb(MID, 3'h0);
    repeat (45) @(posedge core_clk);
    stb(HI, 3'h0);
    idle();
    stb(MID, 3'h0);
    repeat (10) @(posedge core_clk);
    stb(HI, 3'h3);
    stb(MID, 3'h0);
    apb(1'b0, 8'h18, 32'h0, 32'h7);
    apb(1'b1, 8'h0C, 32'h3, 32'h0);
    idle();
    stb(HI, 3'h3);
    repeat (40) @(posedge core_clk);
    stb(HI, 3'h0);
    apb(1'b1, 8'h10, 32'h0, 32'h0);
    idle();
    repeat (4) stb(HI, 3'h3);
    stb(MID, 3'h0);
    // disable drops an active detection and keeps the detector from arming
    idle();
    stb(HI, 3'h3);
    apb(1'b1, 8'h00, 32'h0, 32'h0);
    apb(1'b0, 8'h14, 32'h0, 32'h4);
    idle();
    stb(HI, 3'h0);
    apb(1'b1, 8'h00, 32'h1, 32'h0);
    repeat (4) @(posedge core_clk);
    chk("blk_cnt", 32'h6, {24'h0, blk_cnt});
    conclude();
  end
endmodule
